// [adcs_params.svh]
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH
// ****************************************************************
// timing figures, in master clock periods
// ****************************************************************
`define ADCS_GUARD_PERIODS 20
`define ADCS_GUARD_CYCLES (`ADCS_GUARD_PERIODS * 1)
// ****************************************************************
// frame geometry and field positions
// ****************************************************************
`define ADCS_BYTE_BITS 8
`define ADCS_MID_SECOND_BIT 5'h0C
`define ADCS_BIT_CNT_MAX 5'h1F
`define ADCS_SYNC_SS_POS 7
`define ADCS_SYNC_MODE_POS 6
`define ADCS_SYNC_CORE_HI 5
`define ADCS_SYNC_CORE_LO 2
`define ADCS_SYNC_RX_POS 1
`define ADCS_SYNC_MID_POS 0
// ****************************************************************
// reset values and buffer depth
// ****************************************************************
`define ADCS_SYNC_RESET 8'h80
`define ADCS_WORD_RESET 24'h000000
`define ADCS_FIFO_DEPTH 16
`endif

// [adcs_pkg.sv]
package adcs_pkg;
  // one conversion result
  typedef logic [23:0] word_t;
  // one serial byte
  typedef logic [7:0] byte_t;
  // core-select bus
  typedef logic [3:0] core_t;
  // result sequencer states
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_READY = 2'b01,
    ST_READING = 2'b10,
    ST_GUARD = 2'b11
  } state_t;
endpackage : adcs_pkg

// [adcs_fifo.sv]
`timescale 1ns/1ns
module adcs_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_flush,
  // filling side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // draining side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  // storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  // handshakes
  wire push = i_in_valid & o_in_ready;
  wire load = (count != '0) & (~o_out_valid | i_out_ready);
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
  // ****************************************************************
  // storage write, no reset needed on the array
  // ****************************************************************
  always_ff @(posedge i_clk)
  begin
    if (i_ce && push)
      mem[wr_ptr] <= i_in_data;
  end
  // ****************************************************************
  // pointers, count, registered full and output stage
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
      o_out_data <= '0;
    end
    else if (i_ce)
    begin
      if (i_flush)
      begin
        // stale words of the previous core are dropped
        wr_ptr <= '0;
        rd_ptr <= '0;
        count <= '0;
        o_in_ready <= 1'b1;
        o_out_valid <= 1'b0;
      end
      else
      begin
        if (push)
          wr_ptr <= wr_ptr + 1'b1;
        if (load)
        begin
          o_out_data <= mem[rd_ptr];
          rd_ptr <= rd_ptr + 1'b1;
        end
        if (load)
          o_out_valid <= 1'b1;
        else if (i_out_ready)
          o_out_valid <= 1'b0;
        count <= next_count;
        // ready from a flop so the source sees honest back-pressure
        o_in_ready <= (next_count != DEPTH[AW:0]);
      end
    end
  end
endmodule : adcs_fifo

// [adcs_seq.sv]
`timescale 1ns/1ns
`include "adcs_params.svh"
module adcs_seq #(
  parameter int GUARD_CYCLES = `ADCS_GUARD_CYCLES,
  parameter int FIFO_DEPTH = `ADCS_FIFO_DEPTH
) (
  // master clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // serial link
  input wire logic i_sclk,
  input wire logic i_ss_n,
  input wire logic i_din,
  output logic o_dout,
  output logic o_dout_oe_n,
  // control pins
  input wire logic i_mode,
  input wire adcs_pkg::core_t i_core_select,
  output logic o_sample_ready_n,
  // results from the converter cores
  input wire logic i_result_valid,
  input wire adcs_pkg::word_t i_result_data,
  output logic o_result_ready,
  input wire logic i_filter_tick,
  // commands toward the register banks
  output logic o_cmd_valid,
  output adcs_pkg::byte_t o_cmd_byte,
  output logic o_cmd_first,
  output adcs_pkg::core_t o_core_select,
  output logic o_flight
);
  import adcs_pkg::*;
  // ****************************************************************
  // link domain, clocked by sclk
  // ****************************************************************
  // bit counters, shift register and dout are cleared whenever select is high
  wire link_rst_n = i_nrst & ~i_ss_n;
  logic [4:0] rx_cnt; // rising edges seen in this frame
  logic [7:0] rx_shift; // incoming bits
  byte_t rx_byte; // last complete byte, steady for a byte time
  logic rx_first; // that byte opened the frame
  logic rx_tgl; // flips once per byte
  logic mid_tgl; // flips midway through second byte, in flight mode only
  logic [4:0] tx_idx; // falling edges seen in this frame
  word_t out_word; // held result, mclk domain
  logic mode_f; // filtered mode, mclk domain
  wire [7:0] next_rx_shift = {rx_shift[6:0], i_din};
  wire rx_done = (rx_cnt[2:0] == 3'h7);
  // din taken on the rising edge
  always_ff @(posedge i_sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      rx_cnt <= 5'h00;
      rx_shift <= 8'h00;
    end
    else
    begin
      rx_shift <= next_rx_shift;
      if (rx_cnt != `ADCS_BIT_CNT_MAX)
        rx_cnt <= rx_cnt + 5'h01;
    end
  end
  // byte and mid-byte events survive the frame end, so no link reset
  always_ff @(posedge i_sclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rx_byte <= 8'h00;
      rx_first <= 1'b0;
      rx_tgl <= 1'b0;
      mid_tgl <= 1'b0;
    end
    else if (!i_ss_n)
    begin
      if (rx_done)
      begin
        rx_byte <= next_rx_shift;
        rx_first <= (rx_cnt[4:3] == 2'h0);
        rx_tgl <= ~rx_tgl;
      end
      if (mode_f && rx_cnt == `ADCS_MID_SECOND_BIT - 5'h01)
        mid_tgl <= ~mid_tgl;
    end
  end
  // dout launched on the falling edge, tri-stated by select high
  always_ff @(negedge i_sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      o_dout <= 1'b0;
      o_dout_oe_n <= 1'b1;
      tx_idx <= 5'h00;
    end
    else
    begin
      // out_word is frozen while select is low, so it is quasi-static here
      o_dout <= mode_f & (tx_idx < 5'h18) & out_word[5'h17 - tx_idx];
      o_dout_oe_n <= 1'b0;
      if (tx_idx != `ADCS_BIT_CNT_MAX)
        tx_idx <= tx_idx + 5'h01;
    end
  end
  // ****************************************************************
  // pin and event synchronisers, mclk domain
  // ****************************************************************
  logic [7:0] sync1; // first stage, read only by sync2
  logic [7:0] sync2;
  logic [7:0] sync3;
  logic [7:0] filt; // a bit moves once stages two and three agree
  logic [7:0] filt_q;
  wire [7:0] raw = {i_ss_n, i_mode, i_core_select, rx_tgl, mid_tgl};
  wire [7:0] agree = ~(sync2 ^ sync3);
  wire [7:0] next_filt = (agree & sync3) | (~agree & filt);
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sync1 <= `ADCS_SYNC_RESET;
      sync2 <= `ADCS_SYNC_RESET;
      sync3 <= `ADCS_SYNC_RESET;
      filt <= `ADCS_SYNC_RESET;
      filt_q <= `ADCS_SYNC_RESET;
    end
    else if (i_ce)
    begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      filt_q <= filt;
    end
  end
  assign mode_f = filt[`ADCS_SYNC_MODE_POS];
  wire ss_f = filt[`ADCS_SYNC_SS_POS];
  wire ss_rise = ss_f & ~filt_q[`ADCS_SYNC_SS_POS];
  wire ss_fall = ~ss_f & filt_q[`ADCS_SYNC_SS_POS];
  wire chg_evt = (filt[6:2] != filt_q[6:2]);
  wire rx_evt = filt[`ADCS_SYNC_RX_POS] ^ filt_q[`ADCS_SYNC_RX_POS];
  wire mid_evt = filt[`ADCS_SYNC_MID_POS] ^ filt_q[`ADCS_SYNC_MID_POS];
  // ****************************************************************
  // result buffer
  // ****************************************************************
  logic buf_valid;
  word_t buf_data;
  state_t state;
  wire take = (state == ST_IDLE) & mode_f & ss_f & ~chg_evt;
  adcs_fifo #(
    .WIDTH(24),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_mclk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_flush(chg_evt),
    .i_in_valid(i_result_valid),
    .i_in_data(i_result_data),
    .o_in_ready(o_result_ready),
    .o_out_valid(buf_valid),
    .o_out_data(buf_data),
    .i_out_ready(take)
  );
  // ****************************************************************
  // ready sequencer
  // ****************************************************************
  logic [4:0] guard_cnt; // cycles left with ready forced high
  logic read_done; // midpoint of second byte reached in this frame
  wire [4:0] guard_init = 5'(GUARD_CYCLES - 1);
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= ST_GUARD;
      guard_cnt <= 5'(GUARD_CYCLES - 1);
      o_sample_ready_n <= 1'b1;
      out_word <= `ADCS_WORD_RESET;
      read_done <= 1'b0;
    end
    else if (i_ce)
    begin
      if (chg_evt)
      begin
        // new core or mode: ready high and counted down first
        state <= ST_GUARD;
        guard_cnt <= guard_init;
        o_sample_ready_n <= 1'b1;
      end
      else
      begin
        case (state)
          ST_GUARD:
          begin
            if (guard_cnt == 5'h00)
              state <= ST_IDLE;
            else
              guard_cnt <= guard_cnt - 5'h01;
          end
          ST_IDLE:
          begin
            // program mode never drops ready low
            if (take && buf_valid)
            begin
              out_word <= buf_data;
              o_sample_ready_n <= 1'b0;
              state <= ST_READY;
            end
          end
          ST_READY:
          begin
            if (ss_fall)
            begin
              read_done <= 1'b0;
              state <= ST_READING;
            end
            else if (i_filter_tick)
            begin
              // unread word expires at the next filter clock
              o_sample_ready_n <= 1'b1;
              state <= ST_IDLE;
            end
          end
          ST_READING:
          begin
            // out_word not touched here, filter clocks are ignored
            if (mid_evt)
            begin
              o_sample_ready_n <= 1'b1;
              read_done <= 1'b1;
            end
            if (ss_rise)
              state <= (read_done | mid_evt) ? ST_IDLE : ST_READY;
          end
          default:
            state <= ST_GUARD;
        endcase
      end
    end
  end
  // ****************************************************************
  // command path, recognised only in program mode
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_cmd_valid <= 1'b0;
      o_cmd_byte <= 8'h00;
      o_cmd_first <= 1'b0;
      o_core_select <= 4'h0;
      o_flight <= 1'b0;
    end
    else if (i_ce)
    begin
      // the byte register is steady for eight sclk periods, ample to cross
      o_cmd_valid <= rx_evt & ~mode_f;
      if (rx_evt)
      begin
        o_cmd_byte <= rx_byte;
        o_cmd_first <= rx_first;
      end
      o_core_select <= filt[`ADCS_SYNC_CORE_HI:`ADCS_SYNC_CORE_LO];
      o_flight <= mode_f;
    end
  end
  // ****************************************************************
  // checks
  // ****************************************************************
  logic [5:0] since_chg; // helper: cycles since last change, saturating
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      since_chg <= 6'h00;
    else if (i_ce)
      since_chg <= chg_evt ? 6'h00 : (since_chg == 6'h3F ? since_chg : since_chg + 6'h01);
  end
  ready_after_guard_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !o_sample_ready_n |-> since_chg >= 6'h14)
    else $error("ready low too soon after a change");
  guard_high_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_ce && chg_evt |=> o_sample_ready_n && state == ST_GUARD)
    else $error("ready not raised on change");
  word_frozen_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    state == ST_READING && $past(state) == ST_READING |-> $stable(out_word))
    else $error("output word moved during read");
  mid_release_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_ce && state == ST_READING && mid_evt && !chg_evt |=> o_sample_ready_n)
    else $error("ready not raised mid second byte");
  short_read_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_ce && state == ST_READING && ss_rise && !read_done && !mid_evt && !chg_evt
      |=> !o_sample_ready_n ##0 state == ST_READY)
    else $error("short read dropped ready");
  prog_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !mode_f && $past(!mode_f) |-> o_sample_ready_n)
    else $error("ready low in program mode");
  cmd_program_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_cmd_valid |-> !o_flight)
    else $error("command passed in flight mode");
  dout_tri_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_ss_n |-> o_dout_oe_n)
    else $error("dout driven while deselected");
  rx_byte_a: assert property (@(posedge i_sclk) disable iff (!link_rst_n)
    rx_done |=> rx_byte == $past(next_rx_shift))
    else $error("received byte not captured");
endmodule : adcs_seq

// [adcs_host.sv]
`timescale 1ns/1ns
// ****
// spi host model: drives clock, select and din
// ****
module adcs_host (
  // link pins toward the device
  output logic o_sclk,
  output logic o_ss_n,
  output logic o_din,
  input wire logic i_dout
);
  // idle: clock stands high, select high
  initial
  begin
    o_sclk = 1'b1;
    o_din = 1'b0;
    // select rises a step late, so the link logic still sees the reset edge at time zero
    #1 o_ss_n = 1'b1;
  end
  // one frame, msb first; gap stretches the pause between bytes
  task automatic xfer(input int nbits, input int gap, input logic [23:0] tx,
    output logic [23:0] rx);
    rx = 24'h000000;
    #7 o_ss_n = 1'b0;
    #100;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      o_sclk = 1'b0;
      o_din = tx[i];
      #63 o_sclk = 1'b1;
      rx = {rx[22:0], i_dout};
      #62;
      // a pause only between bytes, never after the last
      if (i % 8 == 0 && i != 0)
        #(gap);
    end
    #100 o_ss_n = 1'b1;
    // released line shows the inverse, not a stale bit
    o_din = ~o_din;
  endtask : xfer
endmodule : adcs_host

// [adc_serial_access_sequencing_bench.sv]
`timescale 1ns/1ns
module adc_serial_access_sequencing_bench;
  import adcs_pkg::*;
  // ****
  // pins and bookkeeping
  // ****
  logic i_mclk;
  logic i_nrst = 1'b1;
  logic ce = 1'b1;
  logic flight;
  core_t core_sel;
  logic mode = 1'b0;
  core_t core = 4'h0;
  logic res_valid = 1'b0;
  word_t res_data = 24'h000000;
  logic tick = 1'b0;
  logic sclk, ss_n, din, dout, dout_oe_n, ready_n, res_ready, cmd_valid, cmd_first;
  byte_t cmd_byte;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [8:0] cmd_q[$]; // captured bytes with their first flag

  adcs_host u_host (.o_sclk(sclk), .o_ss_n(ss_n), .o_din(din), .i_dout(dout));
  adcs_seq u_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(ce), .i_sclk(sclk),
    .i_ss_n(ss_n), .i_din(din), .o_dout(dout), .o_dout_oe_n(dout_oe_n), .i_mode(mode),
    .i_core_select(core), .o_sample_ready_n(ready_n), .i_result_valid(res_valid),
    .i_result_data(res_data), .o_result_ready(res_ready), .i_filter_tick(tick),
    .o_cmd_valid(cmd_valid), .o_cmd_byte(cmd_byte), .o_cmd_first(cmd_first),
    .o_core_select(core_sel), .o_flight(flight));

  // master clock, 20 ns
  initial
  begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // hang guard, well above the expected run
  always @(posedge i_mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      results();
    end
  end
  // collect every received command byte
  always @(posedge i_mclk)
    if (cmd_valid === 1'b1)
      cmd_q.push_back({cmd_first, cmd_byte});

  // ****
  // helpers
  // ****
  task automatic results();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  task automatic chk_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit
  task automatic chk_word(input word_t got, input word_t exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_word
  // distinct pattern per word, busy upper bits
  function automatic word_t mkw(input int i);
    return {8'hA5, 8'(i), 8'h3C ^ 8'(i)};
  endfunction : mkw
  // bounded wait for a ready level; n counts edges
  task automatic wait_rdy(input logic lvl, input int lim, output int n);
    n = 0;
    while (ready_n !== lvl && n < lim)
    begin
      @(posedge i_mclk);
      n++;
    end
  endtask : wait_rdy
  // one read; checks run off the rising mclk edges to avoid races
  task automatic read_word(input int nbits, input logic pulse, output word_t rx);
    int n;
    wait_rdy(1'b0, 200, n);
    chk_bit(ready_n, 1'b0, "ready before read");
    @(posedge i_mclk);
    fork
      u_host.xfer(nbits, 0, 24'hFFFFFF, rx);
      begin
        #1010 chk_bit(ready_n, 1'b0, "ready early");
        chk_bit(dout_oe_n, 1'b0, "oe in frame");
        if (pulse)
        begin
          @(posedge i_mclk) tick <= 1'b1;
          @(posedge i_mclk) tick <= 1'b0;
        end
        #1410 if (nbits == 24) chk_bit(ready_n, 1'b1, "ready mid read");
      end
    join
    #1 chk_bit(dout_oe_n, 1'b1, "oe released");
    #100;
  endtask : read_word

  // ****
  // scenarios
  // ****
  task automatic program_cmds();
    logic [23:0] rx;
    @(posedge i_mclk) core <= 4'h2;
    repeat (30) @(posedge i_mclk);
    u_host.xfer(16, 250, 24'h005AC3, rx);
    #100;
    repeat (10) @(posedge i_mclk);
    chk_word(24'(cmd_q.size()), 24'h000002, "cmd count");
    chk_word({15'h0, cmd_q[0]}, 24'h00015A, "first byte");
    chk_word({15'h0, cmd_q[1]}, 24'h0000C3, "second byte");
    chk_word({20'h0, core_sel}, 24'h000002, "core out");
    chk_bit(flight, 1'b0, "program flag");
    cmd_q.delete();
  endtask : program_cmds
  // fill the fifo until refused, then drain it with stalls between reads
  task automatic flight_fill_drain();
    word_t rx;
    int n = 0;
    int cnt = 0;
    int first = 0;
    @(posedge i_mclk) mode <= 1'b1;
    repeat (10) @(posedge i_mclk);
    core <= 4'h3;
    res_data <= mkw(0);
    while (n < 60)
    begin
      @(posedge i_mclk);
      n++;
      if (res_valid === 1'b1 && res_ready === 1'b1)
      begin
        cnt++;
        res_data <= mkw(cnt);
      end
      // words start once the change has flushed the buffer
      if (n == 8)
        res_valid <= 1'b1;
      if (ready_n === 1'b0 && first == 0)
        first = n;
    end
    res_valid <= 1'b0;
    chk_bit(first >= 21 && first <= 40, 1'b1, "ready delay");
    chk_bit(res_ready, 1'b0, "fifo refuses");
    // sixteen buffered, one in the output stage, one held for the host
    chk_bit(cnt == 18, 1'b1, "fifo depth");
    chk_bit(flight, 1'b1, "flight flag");
    chk_word({20'h0, core_sel}, 24'h000003, "core out");
    for (int i = 0; i < cnt; i++)
    begin
      if (i == 1)
      begin
        read_word(8, 1'b0, rx);
        chk_word(rx & 24'h0000FF, mkw(i) >> 16, "short read");
        repeat (10) @(posedge i_mclk);
        chk_bit(ready_n, 1'b0, "ready after short");
      end
      read_word(24, i == 0, rx);
      chk_word(rx, mkw(i), "result");
    end
    chk_word(24'(cmd_q.size()), 24'h000000, "no cmd in flight");
  endtask : flight_fill_drain
  // unread word, then a channel change
  task automatic channel_change();
    int n;
    int high = 0;
    @(posedge i_mclk);
    res_valid <= 1'b1;
    res_data <= mkw(99);
    @(posedge i_mclk);
    res_valid <= 1'b0;
    wait_rdy(1'b0, 40, n);
    chk_bit(ready_n, 1'b0, "ready for word");
    core <= 4'h5;
    wait_rdy(1'b1, 8, n);
    chk_bit(ready_n, 1'b1, "ready on change");
    // a word waits during the guard, so ready must fall right after it
    res_valid <= 1'b1;
    res_data <= mkw(7);
    repeat (20)
    begin
      @(posedge i_mclk);
      res_valid <= 1'b0;
      if (ready_n === 1'b1)
        high++;
    end
    chk_bit(high == 20, 1'b1, "ready held high");
    wait_rdy(1'b0, 10, n);
    chk_bit(ready_n, 1'b0, "ready after guard");
  endtask : channel_change
  // a core change is not seen while the enable is low
  task automatic enable_freeze();
    int n;
    @(posedge i_mclk);
    ce <= 1'b0;
    core <= 4'h6;
    repeat (30) @(posedge i_mclk);
    chk_bit(ready_n, 1'b0, "ready frozen");
    ce <= 1'b1;
    wait_rdy(1'b1, 8, n);
    chk_bit(ready_n, 1'b1, "ready after enable");
  endtask : enable_freeze

  // main sequence
  initial
  begin
    // reset edge after every process has started, so none misses it
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_mclk);
    chk_bit(ready_n, 1'b1, "ready in reset");
    chk_bit(dout_oe_n, 1'b1, "oe in reset");
    i_nrst <= 1'b1;
    repeat (30) @(posedge i_mclk);
    program_cmds();
    flight_fill_drain();
    channel_change();
    enable_freeze();
    results();
  end
endmodule : adc_serial_access_sequencing_bench
